// File: verif/sbrc_ctrl_sva.sv
// concurrent checks on the ports of the standby and reset control block
`timescale 1ns/10ps

module sbrc_ctrl_sva #(
  parameter int unsigned WAKE_CYC    = 15000,
  parameter int unsigned READY_CYC   = 1125000,
  parameter int unsigned STEP_CYC    = 12500000,
  parameter int unsigned MIN_LOW_CYC = 1250
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       reset_pin_n,
  input wire logic       alarm,
  input wire logic       attr_wr,
  input wire logic       attr_low_power,
  input wire logic [4:0] attr_idle_code,
  input wire logic       bus_start,
  input wire logic       bus_addressed,
  input wire logic       start_ack,
  input wire logic       start_nack,
  input wire logic       core_reset,
  input wire logic       cmd_ready,
  input wire logic       asleep,
  input wire logic       low_power_mode,
  input wire logic [4:0] idle_code
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  int unsigned low_reg, low_next;   // cycles the pin has been low
  int unsigned wake_reg, wake_next; // cycles since a start woke a sleeper
  int unsigned idle_reg, idle_next; // silent cycles while ready
  // next counts; plain ints so that comparisons with the parameters need no casts
  always_comb
  begin
    low_next  = reset_pin_n ? 0 : low_reg + 1;
    wake_next = (asleep && (bus_start || wake_reg != 0)) ? wake_reg + 1 : 0;
    idle_next = (cmd_ready && !bus_start && !bus_addressed && !attr_wr) ? idle_reg + 1 : 0;
  end
  // counters clear with reset so that no check sees a stale count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      low_reg  <= 0;
      wake_reg <= 0;
      idle_reg <= 0;
    end
    else
    begin
      low_reg  <= low_next;
      wake_reg <= wake_next;
      idle_reg <= idle_next;
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_alarm_on;
    alarm ##1 alarm;
  endsequence
  sequence s_woken;
    asleep ##1 !asleep;
  endsequence
  property p_answer;
    bus_start |-> start_ack == cmd_ready && start_nack == !cmd_ready;
  endproperty
  a_answer: assert property (p_answer) else $error("start answer does not follow readiness");
  property p_quiet;
    core_reset |-> !cmd_ready && !asleep;
  endproperty
  a_quiet: assert property (p_quiet) else $error("ready or asleep while in reset");
  property p_pin_low;
    low_reg == MIN_LOW_CYC + 6 |-> core_reset;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("long pin low gave no reset");
  property p_alarm;
    s_alarm_on |-> ##[1:4] core_reset;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm gave no reset");
  property p_attr;
    attr_wr && cmd_ready |=> low_power_mode == $past(attr_low_power) && idle_code == $past(attr_idle_code);
  endproperty
  a_attr: assert property (p_attr) else $error("attribute write not stored");
  property p_attr_keep;
    !(attr_wr && cmd_ready) |=> $stable(low_power_mode) && $stable(idle_code);
  endproperty
  a_attr_keep: assert property (p_attr_keep) else $error("attribute changed without a write");
  property p_wake_max;
    wake_reg <= WAKE_CYC + 2;
  endproperty
  a_wake_max: assert property (p_wake_max) else $error("wake-up took too long");
  property p_wake_min;
    s_woken |-> core_reset || (cmd_ready && $past(wake_reg) >= WAKE_CYC - 1);
  endproperty
  a_wake_min: assert property (p_wake_min) else $error("woke before the wake delay");
  property p_sleep_lp;
    asleep |-> low_power_mode;
  endproperty
  a_sleep_lp: assert property (p_sleep_lp) else $error("asleep with standby off");
  property p_idle_max;
    cmd_ready && low_power_mode |-> idle_reg <= (idle_code + 1) * STEP_CYC + 1;
  endproperty
  a_idle_max: assert property (p_idle_max) else $error("idle interval overrun");
endmodule : sbrc_ctrl_sva

bind sbrc_ctrl sbrc_ctrl_sva #(
  .WAKE_CYC(WAKE_CYC), .READY_CYC(READY_CYC), .STEP_CYC(STEP_CYC), .MIN_LOW_CYC(MIN_LOW_CYC)
) u_sbrc_ctrl_sva (
  .clk, .rst, .reset_pin_n, .alarm, .attr_wr, .attr_low_power, .attr_idle_code, .bus_start,
  .bus_addressed, .start_ack, .start_nack, .core_reset, .cmd_ready, .asleep, .low_power_mode, .idle_code
);

// File: verif/sbrc_ctrl_test.sv
// self-checking testbench for the standby and reset control block
`timescale 1ns/10ps

module sbrc_ctrl_test;
  localparam int unsigned WAKE  = 10; // shortened counts keep the run brief
  localparam int unsigned READY = 50;
  localparam int unsigned STEP  = 20;
  localparam int unsigned MINLO = 8;
  localparam int unsigned GAP   = 15; // poll gap: above wake, below one idle step
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       alarm = 1'b0;
  logic       attr_wr = 1'b0;
  logic       attr_low_power = 1'b0;
  logic [4:0] attr_idle_code = 5'h00;
  logic       poll = 1'b0;
  logic       pin_low = 1'b1;
  logic       reset_pin_n, bus_start, bus_addressed, start_ack, start_nack;
  logic       core_reset, cmd_ready, asleep, low_power_mode;
  logic [4:0] idle_code;
  logic       exp_q[$]; // expected answer per start, 1 for ack
  logic       exp_a;    // oldest note taken off the queue
  int         n_errors = 0;
  int         n_compared = 0;
  int         cycles = 0;
  int         seed = 32'h1c1f_a561;
  int         n;
  int         code;
  sbrc_ctrl #(.WAKE_CYC(WAKE), .READY_CYC(READY), .STEP_CYC(STEP), .MIN_LOW_CYC(MINLO)) u_sbrc_ctrl (
    .clk, .rst, .reset_pin_n, .alarm, .attr_wr, .attr_low_power, .attr_idle_code, .bus_start,
    .bus_addressed, .start_ack, .start_nack, .core_reset, .cmd_ready, .asleep, .low_power_mode, .idle_code
  );
  sbrc_host_model u_sbrc_host_model (.clk, .poll, .pin_low, .bus_start, .bus_addressed, .reset_pin_n);
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task check(input string what, input logic [4:0] exp, input logic [4:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task in_range(input string what, input int v, input int lo, input int hi);
    n_compared++;
    if (v < lo || v > hi)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, v);
    end
  endtask : in_range
  // one start through the host; the monitor pairs the answer with the note
  task poll_start(input logic ack);
    exp_q.push_back(ack);
    poll = 1'b1;
    @(negedge clk);
    poll = 1'b0;
    @(negedge clk);
  endtask : poll_start
  task pin_pulse(input int len);
    pin_low = 1'b1;
    repeat (len) @(negedge clk);
    pin_low = 1'b0;
  endtask : pin_pulse
  task write_attr(input logic lp, input logic [4:0] c);
    attr_wr = 1'b1;
    attr_low_power = lp;
    attr_idle_code = c;
    @(negedge clk);
    attr_wr = 1'b0;
    attr_idle_code = ~c; // value is only sampled with the strobe
    @(negedge clk);
  endtask : write_attr
  // bounded wait for ready (sel 0) or asleep (sel 1), counting cycles
  task wait_for(input logic sel, output int cnt);
    cnt = 0;
    while ((sel ? asleep : cmd_ready) !== 1'b1 && cnt < 2000)
    begin
      @(negedge clk);
      cnt++;
    end
  endtask : wait_for
  task end_test(input string name);
    $display("test %s done, %0d errors so far", name, n_errors);
  endtask : end_test
  task test_done;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////
  // answers to starts are compared with the oldest note
  always @(posedge clk)
  begin
    if (start_ack === 1'b1 || start_nack === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unexpected start answer", 1'b0, 1'b1);
      else
      begin
        exp_a = exp_q.pop_front();
        check("start_ack", exp_a, start_ack);
        check("start_nack", !exp_a, start_nack);
      end
    end
  end
  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_errors++;
      test_done();
    end
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    check("core_reset", 1'b1, core_reset);
    check("low_power_mode", 1'b0, low_power_mode);
    check("idle_code", 5'h00, idle_code);
    poll_start(1'b0);
    pin_low = 1'b0;
    wait_for(1'b0, n);
    in_range("ready delay", n, READY, READY + 6);
    end_test("power-on");
    code = $random(seed) & 31;
    write_attr(1'b1, code[4:0]);
    check("low_power_mode", 1'b1, low_power_mode);
    check("idle_code", code[4:0], idle_code);
    wait_for(1'b1, n);
    in_range("idle time", n, (code + 1) * STEP - 2, (code + 1) * STEP + 2);
    poll_start(1'b0);
    poll_start(1'b0);
    repeat (5)
    begin
      repeat (GAP) @(negedge clk);
      poll_start(1'b1);
    end
    check("asleep", 1'b0, asleep);
    write_attr(1'b0, 5'h00);
    repeat (STEP * 3) @(negedge clk);
    check("asleep", 1'b0, asleep);
    end_test("standby");
    pin_pulse(($random(seed) & 3) + 2);
    repeat (10) @(negedge clk);
    check("core_reset", 1'b0, core_reset);
    // the longest low that must still be ignored
    pin_pulse(MINLO - 1);
    repeat (10) @(negedge clk);
    check("core_reset", 1'b0, core_reset);
    // the shortest low that must reset; core_reset then stands for one cycle only
    pin_pulse(MINLO);
    repeat (3) @(negedge clk);
    check("core_reset", 1'b1, core_reset);
    wait_for(1'b0, n);
    in_range("short warm reset", n, READY, READY + 6);
    pin_pulse(MINLO + 8);
    check("core_reset", 1'b1, core_reset);
    wait_for(1'b0, n);
    in_range("warm reset", n, READY, READY + 6);
    end_test("reset pin");
    alarm = 1'b1;
    repeat (3) @(negedge clk);
    alarm = 1'b0;
    repeat (5) @(negedge clk);
    poll_start(1'b0);
    repeat (READY * 2) @(negedge clk);
    check("core_reset", 1'b1, core_reset);
    pin_pulse(MINLO + 8);
    wait_for(1'b0, n);
    in_range("alarm release", n, READY, READY + 6);
    end_test("alarm");
    test_done();
  end
endmodule : sbrc_ctrl_test

// File: verif/sbrc_host_model.sv
// host controller model: drives the reset pin and issues start conditions
`timescale 1ns/10ps

module sbrc_host_model (
  input  wire logic clk,
  input  wire logic poll,
  input  wire logic pin_low,
  output logic      bus_start,
  output logic      bus_addressed,
  output logic      reset_pin_n
);
  logic pend_reg = 1'b0; // poll request seen on the sampling edge
  initial bus_start = 1'b0;
  initial bus_addressed = 1'b0;
  // reset pin comes from a host output; low while asked, so power-on starts in reset
  assign reset_pin_n = !pin_low;
  always @(posedge clk)
    pend_reg <= poll;
  // one start per request, launched off the falling edge after the sampling edge; retry pacing is left to the bench
  always @(negedge clk)
  begin
    bus_start     <= pend_reg;
    bus_addressed <= pend_reg;
  end
endmodule : sbrc_host_model

// File: verilog/sbrc_ctrl.sv
// standby and reset control: sleep entry, wake delay, reset pin, alarm latch
// Requirements on this block and its host
// [R1] low-power setting changes only by attribute write
// [R2] refuse starts in standby until wake done
// [R3] wake-up completes after 60 us delay
// [R4] idle bus timer puts device to sleep
// [R5] idle interval 50 ms to 1600 ms steps
// [R6] host polls between wake and idle times
// [R7] host should keep standby on shared bus
// [R8] detector alarm latches reset until reset event
// [R9] host should drive reset pin from output
// [R10] reset pin low holds device in reset
// [R11] low pulses under 5 us are ignored
// [R12] floating pin held low keeps reset
// [R13] high-low-high on pin gives warm reset
// [R14] accept commands only after ready delay
// [R15] host holds pin low during power-on
// [R16] host keeps pin low while unpowered
// [R17] addressed traffic restarts idle, start wakes
`timescale 1ns/10ps

module sbrc_ctrl #(
  parameter int unsigned WAKE_CYC   = sbrc_pkg::WAKE_DELAY_CYC,
  parameter int unsigned READY_CYC  = sbrc_pkg::BUS_READY_DELAY_CYC,
  parameter int unsigned STEP_CYC   = sbrc_pkg::IDLE_STEP_CYC,
  parameter int unsigned MIN_LOW_CYC = sbrc_pkg::RESET_MIN_PULSE_WIDTH_CYC
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              reset_pin_n,
  input  wire logic                              alarm,
  input  wire logic                              attr_wr,
  input  wire logic                              attr_low_power,
  input  wire logic [sbrc_pkg::IDLE_CODE_W-1:0]  attr_idle_code,
  input  wire logic                              bus_start,
  input  wire logic                              bus_addressed,
  output logic                                   start_ack,
  output logic                                   start_nack,
  output logic                                   core_reset,
  output logic                                   cmd_ready,
  output logic                                   asleep,
  output logic                                   low_power_mode,
  output logic [sbrc_pkg::IDLE_CODE_W-1:0]       idle_code
);

  ////////////////////////////////////////////////////////////////////////////////
  // counter sizing and elaboration checks

  localparam int unsigned DW = $clog2(((READY_CYC > WAKE_CYC) ? READY_CYC : WAKE_CYC) + 1);
  localparam int unsigned SW = $clog2(STEP_CYC + 1);
  localparam int unsigned KW = sbrc_pkg::IDLE_CODE_W;

  // a zero delay would let the state machine skip a state's wait
  if (WAKE_CYC < 1 || READY_CYC < 1 || STEP_CYC < 1)
  begin : g_bad
    $error("delay counts must be at least one");
  end

  // the idle code must reach the longest interval of the range
  if ((1 << KW) < sbrc_pkg::IDLE_STEPS_MAX)
  begin : g_bad_code
    $error("idle code too narrow for the interval range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset pin filter

  logic pin_held;    // qualified low on the pin
  logic pin_rise;    // qualified low has ended: the warm reset edge

  sbrc_pin_filter #(
    .MIN_LOW_CYC (MIN_LOW_CYC)
  ) u_filter (
    .clk        (clk),
    .rst        (rst),
    .pin_n      (reset_pin_n),
    .held_low   (pin_held),
    .rise_pulse (pin_rise)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // alarm synchroniser and latch

  logic alarm_s1_reg;   // first stage, read only by the second
  logic alarm_s2_reg;   // synchronised alarm
  logic latch_reg;      // alarm latched reset
  logic latch_next;

  // the detectors run off their own timing, so the alarm passes two flip-flops first
  // a latched alarm stays until the pin produces a qualified low
  always_comb
  begin
    latch_next = latch_reg;
    if (pin_held)
    begin
      latch_next = 1'b0;                 // [R8]
    end
    else if (alarm_s2_reg)
    begin
      latch_next = 1'b1;                 // [R8]
    end
  end

  // alarm registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      alarm_s1_reg <= 1'b0;
      alarm_s2_reg <= 1'b0;
      latch_reg    <= 1'b0;
    end
    else
    begin
      alarm_s1_reg <= alarm;
      alarm_s2_reg <= alarm_s1_reg;
      latch_reg    <= latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // low-power attribute

  sbrc_pkg::sbrc_lp_type lp_reg;     // none or standby
  sbrc_pkg::sbrc_lp_type lp_next;
  logic [KW-1:0]         code_reg;   // idle interval in steps minus one
  logic [KW-1:0]         code_next;

  // only the attribute write changes the setting, and only when ready
  always_comb
  begin
    lp_next   = lp_reg;
    code_next = code_reg;
    if (attr_wr && cmd_ready)
    begin
      lp_next   = sbrc_pkg::sbrc_lp_type'(attr_low_power);  // [R1]
      code_next = attr_idle_code;                            // [R5]
    end
  end

  // limitation: the setting is volatile, a power cycle returns it to none
  // attribute registers; kept across warm resets like stored settings
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lp_reg   <= sbrc_pkg::sbrc_lp_type'(sbrc_pkg::LOW_POWER_RESET);
      code_reg <= sbrc_pkg::IDLE_CODE_RESET;
    end
    else
    begin
      lp_reg   <= lp_next;
      code_reg <= code_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power state machine with delay, step and idle counters

  sbrc_pkg::sbrc_state_type state_reg;
  sbrc_pkg::sbrc_state_type state_next;
  // the ready and wake waits never overlap, so one counter sized for the
  // longer of the two serves both and saves flip-flops
  logic [DW-1:0]            dly_reg;    // ready or wake delay count
  logic [DW-1:0]            dly_next;
  logic [SW-1:0]            step_reg;   // cycles within one 50 ms step
  logic [SW-1:0]            step_next;
  logic [KW-1:0]            idle_reg;   // whole idle steps seen
  logic [KW-1:0]            idle_next;
  logic                     hold_rst;   // any cause of reset

  // pin low, floating pin or latched alarm all hold the core in reset
  // a floating pin reads low through the pull-down, so it lands here too
  assign hold_rst = pin_held | latch_reg;   // [R10] [R12]

  // next state; any cause of reset takes priority over every state, so a
  // pin low or alarm in the middle of a wake or a ready wait restarts the
  // whole sequence
  always_comb
  begin
    state_next = state_reg;
    dly_next   = dly_reg;
    step_next  = step_reg;
    idle_next  = idle_reg;
    if (hold_rst)
    begin
      state_next = sbrc_pkg::ST_RESET;      // [R10]
      dly_next   = '0;
    end
    else
    begin
      unique case (state_reg)
        sbrc_pkg::ST_RESET:
        begin
          // leave only on the end of a qualified low: a glitch never sets
          // held, so it cannot make the rising edge that lets us out
          dly_next = '0;
          if (pin_rise)
          begin
            state_next = sbrc_pkg::ST_READY;  // [R11] [R13]
          end
        end
        sbrc_pkg::ST_READY:
        begin
          // commands wait out the bus ready delay
          if (dly_reg == DW'(READY_CYC - 1))  // [R14]
          begin
            state_next = sbrc_pkg::ST_ACTIVE;
            step_next  = '0;
            idle_next  = '0;
          end
          else
          begin
            dly_next = dly_reg + DW'(1);
          end
        end
        sbrc_pkg::ST_ACTIVE:
        begin
          // addressed traffic, an attribute write or standby off restart the
          // idle count; the write restart also keeps a smaller new code from
          // being overtaken by a count that is already higher
          if (bus_addressed || bus_start || attr_wr || lp_reg == sbrc_pkg::LP_NONE)
          begin
            step_next = '0;                  // [R17]
            idle_next = '0;
          end
          else if (step_reg != SW'(STEP_CYC - 1))
          begin
            step_next = step_reg + SW'(1);
          end
          else if (idle_reg == code_reg)
          begin
            state_next = sbrc_pkg::ST_SLEEP; // [R4]
          end
          else
          begin
            step_next = '0;
            idle_next = idle_reg + KW'(1);   // [R5]
          end
        end
        sbrc_pkg::ST_SLEEP:
        begin
          // the refused start is what wakes the device
          if (bus_start)
          begin
            state_next = sbrc_pkg::ST_WAKE;  // [R17]
            dly_next   = '0;
          end
        end
        sbrc_pkg::ST_WAKE:
        begin
          if (dly_reg == DW'(WAKE_CYC - 1))  // [R3]
          begin
            state_next = sbrc_pkg::ST_ACTIVE;
            step_next  = '0;
            idle_next  = '0;
          end
          else
          begin
            dly_next = dly_reg + DW'(1);
          end
        end
        default:
        begin
          state_next = sbrc_pkg::ST_RESET;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= sbrc_pkg::ST_RESET;
      dly_reg   <= '0;
      step_reg  <= '0;
      idle_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      dly_reg   <= dly_next;
      step_reg  <= step_next;
      idle_reg  <= idle_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // start answer is combinational so the target logic sees it in the same cycle
  assign start_ack  = bus_start & (state_reg == sbrc_pkg::ST_ACTIVE) & ~hold_rst;
  assign start_nack = bus_start & ~start_ack;  // [R2]

  // these decode the state register or read the attribute registers only, so
  // they never glitch with the bus inputs
  assign core_reset     = (state_reg == sbrc_pkg::ST_RESET);
  assign cmd_ready      = (state_reg == sbrc_pkg::ST_ACTIVE);  // [R14]
  assign asleep         = (state_reg == sbrc_pkg::ST_SLEEP) | (state_reg == sbrc_pkg::ST_WAKE);
  assign low_power_mode = lp_reg;
  assign idle_code      = code_reg;

endmodule : sbrc_ctrl

// File: verilog/sbrc_pin_filter.sv
// synchroniser and glitch filter for the active-low reset pin
`timescale 1ns/10ps

module sbrc_pin_filter #(
  parameter int unsigned MIN_LOW_CYC = 1250
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_n,
  output logic      held_low,
  output logic      rise_pulse
);

  localparam int unsigned CW = $clog2(MIN_LOW_CYC + 1);

  // elaboration check: a zero threshold would pass every glitch
  if (MIN_LOW_CYC < 1)
  begin : g_bad
    $error("MIN_LOW_CYC must be at least one");
  end

  logic          sync1_reg;   // first stage, read only by the second
  logic          sync2_reg;   // synchronised pin level
  logic [CW-1:0] cnt_reg;     // length of the current low run
  logic [CW-1:0] cnt_next;
  logic          held_reg;    // low run has reached the threshold
  logic          held_next;
  logic          rise_reg;    // one cycle after a qualified low ends
  logic          rise_next;

  // a low run shorter than the threshold never asserts held
  always_comb
  begin
    cnt_next  = cnt_reg;
    held_next = held_reg;
    rise_next = 1'b0;
    if (sync2_reg)
    begin
      // pin high: a qualified low just ended means a warm reset
      cnt_next  = '0;
      held_next = 1'b0;
      rise_next = held_reg;
    end
    // the MIN_LOW_CYC-th low sample sets held, so a low of exactly the minimum width counts
    else if (cnt_reg != CW'(MIN_LOW_CYC - 1))
    begin
      cnt_next = cnt_reg + CW'(1);
    end
    else
    begin
      held_next = 1'b1;
    end
  end

  // registers; an unconnected pin reads low through the pull-down and holds
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      cnt_reg   <= '0;
      held_reg  <= 1'b1;
      rise_reg  <= 1'b0;
    end
    else
    begin
      sync1_reg <= pin_n;
      sync2_reg <= sync1_reg;
      cnt_reg   <= cnt_next;
      held_reg  <= held_next;
      rise_reg  <= rise_next;
    end
  end

  assign held_low   = held_reg;
  assign rise_pulse = rise_reg;

endmodule : sbrc_pin_filter

// File: verilog/sbrc_pkg.sv
// package of constants and types for the standby and reset control block
package sbrc_pkg;

  // clock rate in kHz so that cycle counts stay integer
  localparam int unsigned CLK_KHZ = 250000;

  // standby wake delay, typical, in microseconds
  localparam int unsigned WAKE_DELAY_US = 60;
  localparam int unsigned WAKE_DELAY_CYC = (WAKE_DELAY_US * CLK_KHZ + 999) / 1000;

  // least low time on the reset pin that counts, in microseconds
  localparam int unsigned RESET_MIN_PULSE_WIDTH_US = 5;
  localparam int unsigned RESET_MIN_PULSE_WIDTH_CYC = (RESET_MIN_PULSE_WIDTH_US * CLK_KHZ + 999) / 1000;

  // bus ready delay after reset, in microseconds (typical figure; the longest allowed follows)
  localparam int unsigned BUS_READY_DELAY_US = 4500;
  localparam int unsigned BUS_READY_DELAY_MAX_US = 20000;
  localparam int unsigned BUS_READY_DELAY_CYC = (BUS_READY_DELAY_US * CLK_KHZ) / 1000;

  // idle interval step and range, in milliseconds
  localparam int unsigned IDLE_STEP_MS = 50;
  localparam int unsigned IDLE_MAX_MS = 1600;
  localparam int unsigned IDLE_STEP_CYC = IDLE_STEP_MS * CLK_KHZ;
  localparam int unsigned IDLE_STEPS_MAX = IDLE_MAX_MS / IDLE_STEP_MS;

  // width of the step code; code k means (k+1) steps
  localparam int unsigned IDLE_CODE_W = 5;

  // reset values of the low-power attribute and the idle code
  localparam logic       LOW_POWER_RESET = 1'b0;
  localparam logic [4:0] IDLE_CODE_RESET = 5'h0_0;

  // low-power setting
  typedef enum logic
  {
    LP_NONE    = 1'b0,
    LP_STANDBY = 1'b1
  } sbrc_lp_type;

  // power state machine, one-hot
  typedef enum logic [4:0]
  {
    ST_RESET  = 5'b0_0001,
    ST_READY  = 5'b0_0010,
    ST_ACTIVE = 5'b0_0100,
    ST_SLEEP  = 5'b0_1000,
    ST_WAKE   = 5'b1_0000
  } sbrc_state_type;

endpackage : sbrc_pkg
